// file: design/restart_pkg.sv
// Purpose: Shared constants and carriers for the auto restart sequencer
// Assumes: 100 MHz system clock, 32-bit AHB-Lite register bus
// Notes: Times are in 0.1 s ticks
package restart_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned TICK_MS = 100;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned FREE_WINDOW_S = 60;
   localparam int unsigned FREE_WINDOW_TICKS = FREE_WINDOW_S * 1000 / TICK_MS;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_LIMIT = 8'h04;
   localparam logic [7:0] OFS_WAIT = 8'h08;
   localparam logic [7:0] OFS_SEARCH_OPT = 8'h0c;
   localparam logic [7:0] OFS_SEARCH_CUR = 8'h10;
   localparam logic [7:0] OFS_SEARCH_P = 8'h14;
   localparam logic [7:0] OFS_SEARCH_I = 8'h18;
   localparam logic [7:0] OFS_SEARCH_BLK = 8'h1c;
   localparam logic [7:0] OFS_STATUS = 8'h20;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
   // Reset values and limits
   localparam logic [3:0] LIMIT_MAX = 4'ha;
   localparam logic [9:0] WAIT_MAX = 10'h258;
   localparam logic [9:0] WAIT_RST = 10'h00a;
   localparam logic [7:0] CUR_MIN = 8'h50;
   localparam logic [7:0] CUR_MAX = 8'hc8;
   localparam logic [7:0] CUR_RST = 8'h96;
   localparam logic [13:0] GAIN_MAX = 14'h270f;
   localparam logic [13:0] P_RST = 14'h0064;
   localparam logic [13:0] I_RST = 14'h00c8;
   localparam logic [3:0] OPT_RST = 4'h0;
   localparam int unsigned OPT_AFTER_TRIP = 2;
   // Interrupt status bits
   localparam int unsigned EV_TRIP = 0;
   localparam int unsigned EV_RESTART = 1;
   localparam int unsigned EV_EXHAUSTED = 2;
   localparam int unsigned EV_RECOVER = 3;

   typedef enum logic [2:0] {
      ST_IDLE, ST_RUN, ST_WAIT, ST_BLOCK, ST_STOPPED
   } state_t;

   // Fault causes reported by trip detection
   typedef struct packed {
      logic low_voltage;
      logic estop;
      logic overheat;
      logic hw_diag;
   } trip_cause_t;

   // Speed search settings handed to the output stage
   typedef struct packed {
      logic [7:0] current;
      logic [13:0] prop;
      logic [13:0] integ;
   } search_cfg_t;
endpackage : restart_pkg

// file: design/drive_auto_restart_sequencer.sv
// Purpose: Automatic restart after fault trip with speed search hand-off
// Assumes: Trip inputs are synchronous to mclk_in
// Notes: Registers on AHB-Lite, zero wait states
`timescale 1ns/1ps
// Behaviour
// - Restart only when restart select is one
// - Restart select holds 0 or 1, default 0
// - Retry limit 0 to 10, default 0
// - Wait retry delay 0-60 s before restart
// - Restart decrements counter; none at zero
// - Sixty fault-free seconds increment counter
// - Recovery never raises counter above retry limit
// - No restart after excluded fault causes
// - Restart accelerates via speed search
// - Search current 80-200 percent, default 150
// - Proportional gain 0-9999, default 100
// - Integral gain 0-9999, default 200
// - Output blocked for block time first
// - Option bit 2 enables search after trip
module drive_auto_restart_sequencer #(
   parameter int unsigned TICK_CYCLES = restart_pkg::TICK_CYCLES) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // AHB-Lite slave
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // Drive status
   input wire logic trip_in,
   input wire restart_pkg::trip_cause_t cause_in,
   input wire logic run_in,
   // Output stage control
   output logic restart_out,
   output logic output_block_out,
   output logic search_enable_out,
   output restart_pkg::search_cfg_t search_cfg_out,
   output logic [3:0] retries_left_out,
   output logic irq_out
);
   logic restart_on_reset_select;
   logic [3:0] retry_limit_setting;
   logic [9:0] retry_wait_setting;
   logic [3:0] search_option_bits;
   logic [7:0] search_current_setting;
   logic [13:0] search_prop_setting;
   logic [13:0] search_integral_setting;
   logic [9:0] search_block_setting;
   logic [3:0] irq_stat;
   logic [3:0] irq_mask;
   restart_pkg::state_t state;
   logic [3:0] retries;
   logic [23:0] tick_cnt;
   logic tick;
   logic [9:0] phase_ticks;
   logic [12:0] free_ticks;
   logic free_armed;
   logic trip_q;
   logic trip_edge;
   logic excluded;
   logic ph_write;
   logic ph_read;
   logic [7:0] ph_addr;
   logic acc;
   logic [3:0] ev;
   logic restart_now;
   logic recover_now;
   logic stat_read;
   logic [31:0] wd;

   assign acc = hsel_in && hready_in && htrans_in[1];
   assign wd = hwdata_in;
   assign trip_edge = trip_in && !trip_q;
   assign excluded = cause_in.low_voltage || cause_in.estop ||
                     cause_in.overheat || cause_in.hw_diag;
   assign stat_read = ph_read && (ph_addr == restart_pkg::OFS_IRQ_STAT);

   // Bus address phase capture
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         ph_write <= 1'b0;
         ph_read <= 1'b0;
         ph_addr <= 8'h00;
      end else begin
         ph_write <= acc && hwrite_in;
         ph_read <= acc && !hwrite_in;
         if (acc) begin
            ph_addr <= haddr_in[7:0];
         end
      end
   end

   // Setting registers written in data phase
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         restart_on_reset_select <= 1'b0;
         retry_limit_setting <= 4'h0;
         retry_wait_setting <= restart_pkg::WAIT_RST;
         search_option_bits <= restart_pkg::OPT_RST;
         search_current_setting <= restart_pkg::CUR_RST;
         search_prop_setting <= restart_pkg::P_RST;
         search_integral_setting <= restart_pkg::I_RST;
         search_block_setting <= restart_pkg::WAIT_RST;
         irq_mask <= 4'h0;
      end else if (ph_write) begin
         if (ph_addr == restart_pkg::OFS_CTRL && wd[31:1] == 31'h0) begin
            restart_on_reset_select <= wd[0];
         end else if (ph_addr == restart_pkg::OFS_LIMIT &&
                      wd <= 32'(restart_pkg::LIMIT_MAX)) begin
            retry_limit_setting <= wd[3:0];
         end else if (ph_addr == restart_pkg::OFS_WAIT &&
                      wd <= 32'(restart_pkg::WAIT_MAX)) begin
            retry_wait_setting <= wd[9:0];
         end else if (ph_addr == restart_pkg::OFS_SEARCH_OPT &&
                      wd[31:4] == 28'h0) begin
            search_option_bits <= wd[3:0];
         end else if (ph_addr == restart_pkg::OFS_SEARCH_CUR &&
                      wd >= 32'(restart_pkg::CUR_MIN) &&
                      wd <= 32'(restart_pkg::CUR_MAX)) begin
            search_current_setting <= wd[7:0];
         end else if (ph_addr == restart_pkg::OFS_SEARCH_P &&
                      wd <= 32'(restart_pkg::GAIN_MAX)) begin
            search_prop_setting <= wd[13:0];
         end else if (ph_addr == restart_pkg::OFS_SEARCH_I &&
                      wd <= 32'(restart_pkg::GAIN_MAX)) begin
            search_integral_setting <= wd[13:0];
         end else if (ph_addr == restart_pkg::OFS_SEARCH_BLK &&
                      wd <= 32'(restart_pkg::WAIT_MAX)) begin
            search_block_setting <= wd[9:0];
         end else if (ph_addr == restart_pkg::OFS_IRQ_MASK) begin
            irq_mask <= wd[3:0];
         end
      end
   end

   // Read data mux
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         hrdata_out <= 32'h0;
      end else if (acc && !hwrite_in) begin
         if (haddr_in[7:0] == restart_pkg::OFS_CTRL) begin
            hrdata_out <= {31'h0, restart_on_reset_select};
         end else if (haddr_in[7:0] == restart_pkg::OFS_LIMIT) begin
            hrdata_out <= {28'h0, retry_limit_setting};
         end else if (haddr_in[7:0] == restart_pkg::OFS_WAIT) begin
            hrdata_out <= {22'h0, retry_wait_setting};
         end else if (haddr_in[7:0] == restart_pkg::OFS_SEARCH_OPT) begin
            hrdata_out <= {28'h0, search_option_bits};
         end else if (haddr_in[7:0] == restart_pkg::OFS_SEARCH_CUR) begin
            hrdata_out <= {24'h0, search_current_setting};
         end else if (haddr_in[7:0] == restart_pkg::OFS_SEARCH_P) begin
            hrdata_out <= {18'h0, search_prop_setting};
         end else if (haddr_in[7:0] == restart_pkg::OFS_SEARCH_I) begin
            hrdata_out <= {18'h0, search_integral_setting};
         end else if (haddr_in[7:0] == restart_pkg::OFS_SEARCH_BLK) begin
            hrdata_out <= {22'h0, search_block_setting};
         end else if (haddr_in[7:0] == restart_pkg::OFS_STATUS) begin
            hrdata_out <= {25'h0, state, retries};
         end else if (haddr_in[7:0] == restart_pkg::OFS_IRQ_STAT) begin
            hrdata_out <= {28'h0, irq_stat};
         end else if (haddr_in[7:0] == restart_pkg::OFS_IRQ_MASK) begin
            hrdata_out <= {28'h0, irq_mask};
         end else begin
            hrdata_out <= 32'h0;
         end
      end
   end

   // Always ready, always OKAY
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end else begin
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         tick_cnt <= 24'h0;
         tick <= 1'b0;
      end else if (tick_cnt == 24'(TICK_CYCLES - 1)) begin
         tick_cnt <= 24'h0;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 24'h1;
         tick <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         trip_q <= 1'b0;
      end else begin
         trip_q <= trip_in;
      end
   end

   assign restart_now = (state == restart_pkg::ST_BLOCK) && tick &&
                        (phase_ticks >= search_block_setting);
   assign recover_now = free_armed && tick &&
      free_ticks == 13'(restart_pkg::FREE_WINDOW_TICKS - 1);

   // Restart sequencer
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= restart_pkg::ST_IDLE;
         phase_ticks <= 10'h0;
      end else begin
         case (state)
            restart_pkg::ST_IDLE: begin
               if (run_in) begin
                  state <= restart_pkg::ST_RUN;
               end
            end
            restart_pkg::ST_RUN: begin
               if (trip_edge) begin
                  phase_ticks <= 10'h0;
                  if (restart_on_reset_select && retries != 4'h0 &&
                      !excluded) begin
                     state <= restart_pkg::ST_WAIT;
                  end else begin
                     state <= restart_pkg::ST_STOPPED;
                  end
               end
            end
            restart_pkg::ST_WAIT: begin
               if (tick) begin
                  if (phase_ticks >= retry_wait_setting) begin
                     phase_ticks <= 10'h0;
                     state <= restart_pkg::ST_BLOCK;
                  end else begin
                     phase_ticks <= phase_ticks + 10'h1;
                  end
               end
            end
            restart_pkg::ST_BLOCK: begin
               if (restart_now) begin
                  state <= restart_pkg::ST_RUN;
               end else if (tick) begin
                  phase_ticks <= phase_ticks + 10'h1;
               end
            end
            default: begin
               if (!trip_in && !run_in) begin
                  state <= restart_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   // Remaining retry counter
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         retries <= 4'h0;
      end else if (state == restart_pkg::ST_IDLE) begin
         retries <= retry_limit_setting;
      end else if (restart_now) begin
         retries <= retries - 4'h1;
      end else if (recover_now && retries < retry_limit_setting) begin
         retries <= retries + 4'h1;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         free_armed <= 1'b0;
         free_ticks <= 13'h0;
      end else if (trip_edge || state != restart_pkg::ST_RUN) begin
         free_armed <= restart_now;
         free_ticks <= 13'h0;
      end else if (recover_now) begin
         free_armed <= 1'b0;
         free_ticks <= 13'h0;
      end else if (free_armed && tick) begin
         free_ticks <= free_ticks + 13'h1;
      end
   end

   // Output stage drive
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         restart_out <= 1'b0;
         output_block_out <= 1'b0;
         search_enable_out <= 1'b0;
         search_cfg_out <= '0;
         retries_left_out <= 4'h0;
      end else begin
         restart_out <= restart_now;
         output_block_out <= (state == restart_pkg::ST_BLOCK) &&
                             !restart_now;
         search_enable_out <= restart_now &&
            search_option_bits[restart_pkg::OPT_AFTER_TRIP];
         search_cfg_out <= {search_current_setting, search_prop_setting,
                            search_integral_setting};
         retries_left_out <= retries;
      end
   end

   assign ev[restart_pkg::EV_TRIP] = trip_edge;
   assign ev[restart_pkg::EV_RESTART] = restart_now;
   assign ev[restart_pkg::EV_EXHAUSTED] = trip_edge && retries == 4'h0;
   assign ev[restart_pkg::EV_RECOVER] = recover_now;

   // Read clears only the bits returned; set wins
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_stat <= 4'h0;
         irq_out <= 1'b0;
      end else begin
         irq_stat <= (irq_stat & ~(stat_read ? hrdata_out[3:0] : 4'h0)) | ev;
         irq_out <= |(((irq_stat & ~(stat_read ? hrdata_out[3:0] : 4'h0)) |
                       ev) & irq_mask);
      end
   end
endmodule : drive_auto_restart_sequencer

// file: verification/restart_checker.sv
// Purpose: Port assertions for the restart sequencer
// Assumes: One clock domain
// Notes: Bound from tb_top
`timescale 1ns/1ps
module restart_checker (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Drive status
   input wire logic trip_in,
   input wire restart_pkg::trip_cause_t cause_in,
   // Outputs
   input wire logic restart_out,
   input wire logic output_block_out,
   input wire logic search_enable_out,
   input wire restart_pkg::search_cfg_t search_cfg_out,
   input wire logic [3:0] retries_left_out,
   input wire logic irq_out
);
   logic armed;
   default clocking @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         armed <= 1'b0;
      end else begin
         armed <= 1'b1;
      end
   end
   chk_single_restart: assert property (
      restart_out |=> !restart_out) else $error("restart pulse too long");
   chk_search_pairs: assert property (
      search_enable_out |-> restart_out) else $error("search without restart");
   chk_retry_left: assert property (
      restart_out |-> $past(retries_left_out) != 4'h0)
      else $error("restart with no retries left");
   chk_retry_cap: assert property (
      retries_left_out <= restart_pkg::LIMIT_MAX)
      else $error("retry counter above limit");
   chk_current_range: assert property (
      armed |-> search_cfg_out.current inside
      {[restart_pkg::CUR_MIN:restart_pkg::CUR_MAX]})
      else $error("search current out of range");
   chk_prop_range: assert property (
      armed |-> search_cfg_out.prop <= restart_pkg::GAIN_MAX)
      else $error("proportional gain out of range");
   chk_integ_range: assert property (
      armed |-> search_cfg_out.integ <= restart_pkg::GAIN_MAX)
      else $error("integral gain out of range");
   chk_block_first: assert property (
      restart_out |-> $past(output_block_out) || $past(output_block_out, 2))
      else $error("restart without output block");
   chk_excluded_cause: assert property (
      $rose(trip_in) && cause_in != 4'h0 |=> !restart_out [*8])
      else $error("restart after excluded cause");
   chk_block_release: assert property (
      $fell(output_block_out) |-> restart_out)
      else $error("output block ended without restart");
   cover property (restart_out && search_enable_out);
   cover property ($rose(trip_in));
   cover property ($rose(irq_out));
   cover property ($fell(irq_out));
endmodule : restart_checker

// file: verification/drive_fault_model.sv
// Purpose: Trip detection and run status model
// Assumes: Commands arrive just after a clock edge
// Notes: Trip holds until cleared; cause holds until the next fault
`timescale 1ns/1ps
module drive_fault_model (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Bench commands
   input wire logic go_in,
   input wire logic fault_in,
   input wire logic clear_in,
   input wire restart_pkg::trip_cause_t kind_in,
   // Drive status
   output logic run_out,
   output logic trip_out,
   output restart_pkg::trip_cause_t cause_out
);
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         run_out <= 1'b0;
         trip_out <= 1'b0;
         cause_out <= 4'h0;
      end else if (clear_in) begin
         run_out <= 1'b0;
         trip_out <= 1'b0;
      end else if (fault_in) begin
         trip_out <= 1'b1;
         cause_out <= kind_in;
      end else if (go_in) begin
         run_out <= 1'b1;
      end
   end
endmodule : drive_fault_model

// file: verification/tb_top.sv
// Purpose: Self-checking bench for the restart sequencer
// Assumes: Zero-wait AHB-Lite slave
// Notes: Tick shortened to ten cycles so restart paths complete
`timescale 1ns/1ps
module tb_top;
   logic mclk_in, rst_in, hsel, hwrite, go, fault, clear;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hready, hresp, trip, run, restart, blk, srch, irq;
   logic [3:0] left;
   restart_pkg::trip_cause_t cause, kind;
   restart_pkg::search_cfg_t cfg;
   int n_mismatch = 0, compares = 0, cycles = 0, odd = 0, o0 = 0;
   logic [7:0] t_ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
      8'h18, 8'h1c};
   logic [31:0] t_rst [8] = '{0, 0, 10, 0, 150, 100, 200, 10};
   logic [31:0] t_bad [8] = '{2, 11, 601, 16, 79, 10000, 10000, 601};
   logic [31:0] t_good [8] = '{1, 10, 600, 4, 200, 9999, 0, 0};
   drive_auto_restart_sequencer #(.TICK_CYCLES(10)) i_dut (
      .mclk_in(mclk_in), .rst_in(rst_in),
      .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
      .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
      .hresp_out(hresp), .trip_in(trip), .cause_in(cause), .run_in(run),
      .restart_out(restart), .output_block_out(blk),
      .search_enable_out(srch), .search_cfg_out(cfg),
      .retries_left_out(left), .irq_out(irq));
   drive_fault_model i_far (.mclk_in(mclk_in), .rst_in(rst_in), .go_in(go),
      .fault_in(fault), .clear_in(clear), .kind_in(kind), .run_out(run),
      .trip_out(trip), .cause_out(cause));
   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   task automatic summarize;
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      @(posedge mclk_in);
      while (hready !== 1'b1) begin
         @(posedge mclk_in);
      end
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge mclk_in);
      while (hready !== 1'b1) begin
         @(posedge mclk_in);
      end
      rd = hrdata;
   endtask : xfer
   task automatic trip_once(input logic [3:0] k);
      kind <= k;
      go <= 1'b1;
      @(posedge mclk_in);
      go <= 1'b0;
      repeat (3) @(posedge mclk_in);
      fault <= 1'b1;
      @(posedge mclk_in);
      fault <= 1'b0;
      repeat (20) @(posedge mclk_in);
   endtask : trip_once
   task automatic untrip;
      clear <= 1'b1;
      @(posedge mclk_in);
      clear <= 1'b0;
      repeat (3) @(posedge mclk_in);
   endtask : untrip
   function automatic logic [31:0] st(input logic [2:0] s,
      input logic [3:0] r);
      return {25'h0, s, r};
   endfunction : st
   always @(posedge mclk_in) begin
      cycles++;
      if (restart === 1'b1 || blk === 1'b1) begin
         odd++;
      end
      if (cycles == 20000) begin
         n_mismatch++;
         summarize();
      end
   end
   initial begin
      {hsel, hwrite, go, fault, clear} <= 5'h00;
      haddr <= 32'h0;
      hwdata <= 32'h0;
      htrans <= 2'h0;
      hsize <= 3'h2;
      kind <= 4'h0;
      rst_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      rst_in <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         xfer(1'b0, t_ofs[i], 32'h0);
         chk(rd, t_rst[i]);
         xfer(1'b1, t_ofs[i], t_bad[i]);
         xfer(1'b0, t_ofs[i], 32'h0);
         chk(rd, t_rst[i]);
         xfer(1'b1, t_ofs[i], t_good[i]);
         xfer(1'b0, t_ofs[i], 32'h0);
         chk(rd, t_good[i]);
      end
      chk({28'h0, cfg[35:32]}, {28'h0, 4'hc});
      chk(cfg[31:0], {4'h8, 14'h270f, 14'h0});
      xfer(1'b1, 8'h30, 32'h5);
      xfer(1'b0, 8'h30, 32'h0);
      chk(rd, 32'h0);
      xfer(1'b0, restart_pkg::OFS_STATUS, 32'h0);
      chk(rd, st(3'h0, 4'ha));
      chk({28'h0, left}, 32'ha);
      xfer(1'b1, restart_pkg::OFS_IRQ_MASK, 32'hf);
      for (int i = 0; i < 4; i++) begin
         trip_once(4'h1 << i);
         xfer(1'b0, restart_pkg::OFS_STATUS, 32'h0);
         chk(rd, st(3'h4, 4'ha));
         chk({31'h0, irq}, 32'h1);
         xfer(1'b0, restart_pkg::OFS_IRQ_STAT, 32'h0);
         chk(rd, 32'h1);
         xfer(1'b0, restart_pkg::OFS_IRQ_STAT, 32'h0);
         chk(rd, 32'h0);
         repeat (3) @(posedge mclk_in);
         chk({31'h0, irq}, 32'h0);
         untrip();
      end
      xfer(1'b1, restart_pkg::OFS_IRQ_MASK, 32'h0);
      xfer(1'b1, restart_pkg::OFS_CTRL, 32'h0);
      trip_once(4'h0);
      chk({31'h0, irq}, 32'h0);
      xfer(1'b0, restart_pkg::OFS_STATUS, 32'h0);
      chk(rd, st(3'h4, 4'ha));
      xfer(1'b0, restart_pkg::OFS_IRQ_STAT, 32'h0);
      chk(rd, 32'h1);
      untrip();
      xfer(1'b1, restart_pkg::OFS_CTRL, 32'h1);
      trip_once(4'h0);
      repeat (1000) @(posedge mclk_in);
      xfer(1'b0, restart_pkg::OFS_STATUS, 32'h0);
      chk(rd, st(3'h2, 4'ha));
      untrip();
      rst_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      rst_in <= 1'b0;
      xfer(1'b0, restart_pkg::OFS_CTRL, 32'h0);
      chk(rd, 32'h0);
      chk({28'h0, left}, 32'h0);
      xfer(1'b1, restart_pkg::OFS_CTRL, 32'h1);
      trip_once(4'h0);
      xfer(1'b0, restart_pkg::OFS_STATUS, 32'h0);
      chk(rd, st(3'h4, 4'h0));
      xfer(1'b0, restart_pkg::OFS_IRQ_STAT, 32'h0);
      chk(rd & 32'h4, 32'h4);
      untrip();
      chk(odd, 0);
      // Two restarts; second one recovers with counter at its limit
      xfer(1'b1, restart_pkg::OFS_LIMIT, 32'h2);
      xfer(1'b1, restart_pkg::OFS_WAIT, 32'h0);
      xfer(1'b1, restart_pkg::OFS_SEARCH_BLK, 32'h2);
      xfer(1'b1, restart_pkg::OFS_SEARCH_OPT, 32'h4);
      for (int j = 0; j < 2; j++) begin
         o0 = odd;
         trip_once(4'h0);
         while (restart !== 1'b1) begin
            @(posedge mclk_in);
         end
         chk({31'h0, srch}, 32'h1);
         chk({31'h0, (odd - o0) >= 10}, 32'h1);
         repeat (2) @(posedge mclk_in);
         chk({28'h0, left}, 32'h1);
         if (j == 1) begin
            xfer(1'b1, restart_pkg::OFS_LIMIT, 32'h1);
         end
         repeat (6100) @(posedge mclk_in);
         chk({28'h0, left}, 32'(2 - j));
         xfer(1'b0, restart_pkg::OFS_IRQ_STAT, 32'h0);
         chk(rd & 32'h8, 32'h8);
         untrip();
      end
      summarize();
   end
endmodule : tb_top
bind drive_auto_restart_sequencer restart_checker i_chk (
   .mclk_in(mclk_in), .rst_in(rst_in), .trip_in(trip_in),
   .cause_in(cause_in), .restart_out(restart_out),
   .output_block_out(output_block_out),
   .search_enable_out(search_enable_out),
   .search_cfg_out(search_cfg_out), .retries_left_out(retries_left_out),
   .irq_out(irq_out));
